// [rtl/cks_clock_switch.sv]
// Clock source enable, stability report and glitch-free source switch logic.
//
// Operation
// - Five sources: two internal, two crystals, clock-in.
// - Select 00 fast int, 01 external, 10 slow.
// - Select 11 also means fast internal oscillator.
// - Select field read-back need not show active source.
// - Fast internal oscillator runs while enable bit set.
// - Reset: both internals on, fast internal selected.
// - Slow internal oscillator always runs after power-up.
// - Internal source active: crystal pins are port pins.
// - Only one external source enabled at once.
// - External field: none, slow, fast, clock-in.
// - Clock-in uses input pin; output pin becomes port.
// - Switch and enable writes need timed access.
// - Stability bits read one when enabled and stable.
// - Disabling the active source is ignored entirely.
// - Selecting disabled source: field updates, clock stays, fault.
// - Unstable target: keep old clock, fault, switch later.
// - Fault clears itself once background switch completes.
// - Fault flag is read-only bit 0 of enable register.
`timescale 1ns/10ps
`include "cks_map.svh"
module cks_clock_switch
  import cks_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `CKS_SETTLE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [`CKS_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_fast_int_ready,
  input wire logic i_slow_int_ready,
  input wire logic i_fast_xtal_ready,
  input wire logic i_slow_xtal_ready,
  input wire logic i_clk_in_ready,
  output logic [7:0] o_rdata,
  output logic [2:0] o_active_source,
  output logic o_fast_int_en,
  output logic o_slow_int_en,
  output logic o_fast_xtal_en,
  output logic o_slow_xtal_en,
  output logic o_clk_in_en,
  output logic o_crystal_in_pin_gpio,
  output logic o_crystal_out_pin_gpio
);

  ////////////////////////////////////////////////////////////////////////////
  // Source helpers.

  function automatic cks_src_e sel_to_src(input logic [1:0] sel,
                                          input logic [1:0] ext);
    cks_src_e src;
    src = CKS_SRC_FAST_INT;
    unique case (cks_sel_e'(sel))
      CKS_SEL_FAST_INT: src = CKS_SRC_FAST_INT;
      CKS_SEL_RESERVED: src = CKS_SRC_FAST_INT;
      CKS_SEL_SLOW_INT: src = CKS_SRC_SLOW_INT;
      CKS_SEL_EXTERNAL: begin
        unique case (cks_ext_e'(ext))
          CKS_EXT_SLOW_XTAL: src = CKS_SRC_SLOW_XTAL;
          CKS_EXT_FAST_XTAL: src = CKS_SRC_FAST_XTAL;
          CKS_EXT_CLK_IN: src = CKS_SRC_CLK_IN;
          CKS_EXT_NONE: src = CKS_SRC_CLK_IN;
        endcase
      end
    endcase
    return src;
  endfunction

  // External select with no external enabled maps to clock-in, which is then
  // seen as disabled, so the request faults instead of silently running on.
  function automatic logic src_on(input cks_src_e src, input logic fio,
                                  input logic [1:0] ext);
    logic on;
    on = 1'b0;
    unique case (src)
      CKS_SRC_FAST_INT: on = fio;
      CKS_SRC_SLOW_INT: on = 1'b1;
      CKS_SRC_FAST_XTAL: on = (ext == 2'(CKS_EXT_FAST_XTAL));
      CKS_SRC_SLOW_XTAL: on = (ext == 2'(CKS_EXT_SLOW_XTAL));
      CKS_SRC_CLK_IN: on = (ext == 2'(CKS_EXT_CLK_IN));
      default: on = 1'b0;
    endcase
    return on;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and stability.

  logic [1:0] sel_field;
  logic [1:0] ext_field;
  logic fio_en;
  logic fault;
  cks_src_e active;
  logic [1:0] next_sel_field;
  logic [1:0] next_ext_field;
  logic next_fio_en;
  logic next_fault;
  cks_src_e next_active;
  logic [7:0] next_rdata;
  logic ta_open;
  logic key_wr;
  logic prot_wr;
  logic st_fio;
  logic st_sio;
  logic st_fxt;
  logic st_sxt;
  logic st_eck;
  cks_src_e target;
  logic target_stable;

  assign key_wr = i_wr && (i_addr == `CKS_OFF_TIMED);
  assign prot_wr = ta_open && i_wr &&
                   (i_addr == `CKS_OFF_SWITCH || i_addr == `CKS_OFF_ENABLE);

  cks_timed_access u_ta (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_key_wr(key_wr),
    .i_key_data(i_wdata),
    .i_other_wr(i_wr && !key_wr),
    .o_open(ta_open)
  );

  cks_settle #(.SETTLE_CYC(SETTLE_CYC)) u_st_fio (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_enable(fio_en),
    .i_ready(i_fast_int_ready), .i_boot_on(1'b0), .o_stable(st_fio)
  );
  cks_settle #(.SETTLE_CYC(SETTLE_CYC)) u_st_sio (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_enable(1'b1),
    .i_ready(i_slow_int_ready), .i_boot_on(1'b0), .o_stable(st_sio)
  );
  cks_settle #(.SETTLE_CYC(SETTLE_CYC)) u_st_fxt (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_enable(ext_field == 2'(CKS_EXT_FAST_XTAL)),
    .i_ready(i_fast_xtal_ready), .i_boot_on(1'b0), .o_stable(st_fxt)
  );
  cks_settle #(.SETTLE_CYC(SETTLE_CYC)) u_st_sxt (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_enable(ext_field == 2'(CKS_EXT_SLOW_XTAL)),
    .i_ready(i_slow_xtal_ready), .i_boot_on(1'b0), .o_stable(st_sxt)
  );
  cks_settle #(.SETTLE_CYC(SETTLE_CYC)) u_st_eck (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_enable(ext_field == 2'(CKS_EXT_CLK_IN)),
    .i_ready(i_clk_in_ready), .i_boot_on(1'b0), .o_stable(st_eck)
  );

  function automatic logic src_stable(input cks_src_e src, input logic a,
                                      input logic b, input logic c,
                                      input logic d, input logic e);
    logic s;
    s = 1'b0;
    unique case (src)
      CKS_SRC_FAST_INT: s = a;
      CKS_SRC_SLOW_INT: s = b;
      CKS_SRC_FAST_XTAL: s = c;
      CKS_SRC_SLOW_XTAL: s = d;
      CKS_SRC_CLK_IN: s = e;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

  assign target = sel_to_src(sel_field, ext_field);
  assign target_stable = src_stable(target, st_fio, st_sio, st_fxt,
                                    st_sxt, st_eck);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, active source and fault flag.

  always_comb begin
    logic [1:0] w_ext;
    logic w_fio;
    cks_src_e w_tgt;
    w_ext = i_wdata[`CKS_BIT_EXT_LO +: 2];
    w_fio = i_wdata[`CKS_BIT_FIO_EN];
    w_tgt = sel_to_src(i_wdata[`CKS_BIT_SEL_LO +: 2], ext_field);
    next_sel_field = sel_field;
    next_ext_field = ext_field;
    next_fio_en = fio_en;
    next_fault = fault;
    next_active = active;
    if (target != active && target_stable) begin
      next_active = target;
      next_fault = 1'b0;
    end
    if (prot_wr && i_addr == `CKS_OFF_SWITCH) begin
      next_sel_field = i_wdata[`CKS_BIT_SEL_LO +: 2];
      if (w_tgt != active) begin
        if (!src_on(w_tgt, fio_en, ext_field) || !src_stable(w_tgt,
            st_fio, st_sio, st_fxt, st_sxt, st_eck)) begin
          next_fault = 1'b1;
          next_active = active;
        end else begin
          next_active = w_tgt;
          next_fault = 1'b0;
        end
      end else begin
        next_active = active;
        next_fault = 1'b0;
      end
    end
    if (prot_wr && i_addr == `CKS_OFF_ENABLE) begin
      // Whole write is dropped if it would stop the running source.
      if (src_on(active, w_fio, w_ext)) begin
        next_ext_field = w_ext;
        next_fio_en = w_fio;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (i_rd && i_addr == `CKS_OFF_SWITCH) begin
      next_rdata[`CKS_BIT_FXT_ST] = st_fxt;
      next_rdata[`CKS_BIT_SXT_ST] = st_sxt;
      next_rdata[`CKS_BIT_FIO_ST] = st_fio;
      next_rdata[`CKS_BIT_ECK_ST] = st_eck;
      next_rdata[`CKS_BIT_SEL_LO +: 2] = sel_field;
    end else if (i_rd && i_addr == `CKS_OFF_ENABLE) begin
      next_rdata[`CKS_BIT_EXT_LO +: 2] = ext_field;
      next_rdata[`CKS_BIT_FIO_EN] = fio_en;
      next_rdata[`CKS_BIT_FAULT] = fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers and outputs.

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_field <= 2'(CKS_SEL_FAST_INT);
      ext_field <= 2'(CKS_EXT_NONE);
      fio_en <= 1'b1;
      fault <= 1'b0;
      active <= CKS_SRC_FAST_INT;
      o_rdata <= 8'h00;
      o_active_source <= 3'h0;
      o_fast_int_en <= 1'b1;
      o_slow_int_en <= 1'b1;
      o_fast_xtal_en <= 1'b0;
      o_slow_xtal_en <= 1'b0;
      o_clk_in_en <= 1'b0;
      o_crystal_in_pin_gpio <= 1'b1;
      o_crystal_out_pin_gpio <= 1'b1;
    end else begin
      sel_field <= next_sel_field;
      ext_field <= next_ext_field;
      fio_en <= next_fio_en;
      fault <= next_fault;
      active <= next_active;
      o_rdata <= next_rdata;
      o_active_source <= 3'(next_active);
      o_fast_int_en <= next_fio_en;
      o_slow_int_en <= 1'b1;
      o_fast_xtal_en <= (next_ext_field == 2'(CKS_EXT_FAST_XTAL));
      o_slow_xtal_en <= (next_ext_field == 2'(CKS_EXT_SLOW_XTAL));
      o_clk_in_en <= (next_ext_field == 2'(CKS_EXT_CLK_IN));
      // Pins follow the running source, not the enable, per the pin mux.
      o_crystal_in_pin_gpio <= (next_active == CKS_SRC_FAST_INT ||
                                next_active == CKS_SRC_SLOW_INT);
      o_crystal_out_pin_gpio <= (next_active == CKS_SRC_FAST_INT ||
                                 next_active == CKS_SRC_SLOW_INT ||
                                 next_active == CKS_SRC_CLK_IN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_active_on;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      src_on(active, fio_en, ext_field);
  endproperty
  a_active_on: assert property (p_active_on)
    else $error("active source is disabled");

  property p_no_ta_no_change;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_wr && !ta_open) |=> ($stable(ext_field) && $stable(fio_en)
                              && $stable(sel_field));
  endproperty
  a_no_ta_no_change: assert property (p_no_ta_no_change)
    else $error("unprotected write changed a register");

  property p_fault_set;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (prot_wr && i_addr == `CKS_OFF_SWITCH &&
       !src_on(sel_to_src(i_wdata[2:1], ext_field), fio_en, ext_field))
      |=> (fault && $stable(active));
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("disabled target did not fault");

  property p_fault_clear;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (fault && target_stable && !prot_wr) |=> (!fault && active == $past(target));
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault not cleared after switch");

  property p_reserved_fast;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (sel_field == 2'(CKS_SEL_RESERVED)) |-> (target == CKS_SRC_FAST_INT);
  endproperty
  a_reserved_fast: assert property (p_reserved_fast)
    else $error("reserved code not fast internal");

  property p_excl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      $onehot0({o_fast_xtal_en, o_slow_xtal_en, o_clk_in_en});
  endproperty
  a_excl: assert property (p_excl)
    else $error("two external sources enabled");

  property p_pins;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (active == CKS_SRC_SLOW_INT) |-> o_crystal_in_pin_gpio;
  endproperty
  a_pins: assert property (p_pins)
    else $error("crystal pin not gpio on internal clock");

  property p_stable_bit;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_rd && i_addr == `CKS_OFF_SWITCH && ext_field == 2'h0)
      |=> (o_rdata[7:6] == 2'b00 && !o_rdata[3]);
  endproperty
  a_stable_bit: assert property (p_stable_bit)
    else $error("disabled source reads stable");

endmodule // cks_clock_switch

// [rtl/cks_map.svh]
// Register offsets, field positions, reset values and codes of the clock switch.
`ifndef CKS_MAP_SVH
`define CKS_MAP_SVH
`define CKS_ADDR_W 8
`define CKS_OFF_SWITCH 8'h96
`define CKS_OFF_ENABLE 8'h97
`define CKS_OFF_TIMED 8'hc7
`define CKS_RST_SWITCH 8'h30
`define CKS_RST_ENABLE 8'h30
`define CKS_KEY_FIRST 8'haa
`define CKS_KEY_SECOND 8'h55
`define CKS_BIT_FXT_ST 7
`define CKS_BIT_SXT_ST 6
`define CKS_BIT_FIO_ST 5
`define CKS_BIT_ECK_ST 3
`define CKS_BIT_SEL_LO 1
`define CKS_BIT_EXT_LO 6
`define CKS_BIT_FIO_EN 5
`define CKS_BIT_FAULT 0
`define CKS_SETTLE_NS 1000
`define CKS_CLK_NS 40
`define CKS_SETTLE_CYC ((`CKS_SETTLE_NS + `CKS_CLK_NS - 1) / `CKS_CLK_NS)
`endif

// [rtl/cks_pkg.sv]
// Types shared by the clock switch modules.
package cks_pkg;
  typedef enum logic [1:0] {
    CKS_SEL_FAST_INT,
    CKS_SEL_EXTERNAL,
    CKS_SEL_SLOW_INT,
    CKS_SEL_RESERVED
  } cks_sel_e;
  typedef enum logic [1:0] {
    CKS_EXT_NONE,
    CKS_EXT_SLOW_XTAL,
    CKS_EXT_FAST_XTAL,
    CKS_EXT_CLK_IN
  } cks_ext_e;
  typedef enum logic [2:0] {
    CKS_SRC_FAST_INT,
    CKS_SRC_SLOW_INT,
    CKS_SRC_FAST_XTAL,
    CKS_SRC_SLOW_XTAL,
    CKS_SRC_CLK_IN
  } cks_src_e;
  typedef enum logic [1:0] {
    CKS_TA_IDLE,
    CKS_TA_HALF,
    CKS_TA_OPEN
  } cks_ta_e;
endpackage

// [rtl/cks_settle.sv]
// Per-source settle counter that reports a source stable after warm-up.
`timescale 1ns/10ps
`include "cks_map.svh"
module cks_settle #(
  parameter int unsigned SETTLE_CYC = `CKS_SETTLE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_ready,
  input wire logic i_boot_on,
  output logic o_stable
);
  localparam int W = $clog2(SETTLE_CYC + 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic stable;
  logic next_stable;

  ////////////////////////////////////////////////////////////////////////////
  // A source that is switched off forgets its warm-up and starts over.
  always_comb begin
    next_count = count;
    next_stable = stable;
    if (!i_enable) begin
      next_count = '0;
      next_stable = 1'b0;
    end else if (!stable && i_ready) begin
      if (count == W'(SETTLE_CYC - 1)) begin
        next_stable = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  // Boot-enabled sources reset unstable, then skip the count and turn stable on the first ready cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
      stable <= 1'b0;
    end else begin
      count <= next_count;
      stable <= next_stable | (i_boot_on & i_enable & ~stable & i_ready);
    end
  end

  // A disabled source must read unstable at once, not one cycle late.
  assign o_stable = stable & i_enable;
endmodule // cks_settle

// [rtl/cks_timed_access.sv]
// Timed-access key sequencer that opens a one-write protection window.
`timescale 1ns/10ps
`include "cks_map.svh"
module cks_timed_access
  import cks_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_key_wr,
  input wire logic [7:0] i_key_data,
  input wire logic i_other_wr,
  output logic o_open
);
  cks_ta_e state;
  cks_ta_e next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Any other write closes a half-open sequence, so keys must be adjacent.
  always_comb begin
    next_state = state;
    if (i_key_wr) begin
      if (i_key_data == `CKS_KEY_FIRST) begin
        next_state = CKS_TA_HALF;
      end else if (state == CKS_TA_HALF && i_key_data == `CKS_KEY_SECOND) begin
        next_state = CKS_TA_OPEN;
      end else begin
        next_state = CKS_TA_IDLE;
      end
    end else if (i_other_wr) begin
      next_state = CKS_TA_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= CKS_TA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign o_open = (state == CKS_TA_OPEN);
endmodule // cks_timed_access

// [verif/cks_clock_switch_tb_top.sv]
// Self-checking testbench of the clock source switch.
`timescale 1ns/10ps
`include "cks_map.svh"
module cks_clock_switch_tb_top
  import cks_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic slow = 1'b0;
  logic [4:0] ready;
  logic [4:0] en;
  logic [7:0] o_rdata;
  logic [2:0] o_active_source;
  logic [1:0] gp;
  int n_mismatch = 0;
  int n_tests = 0;
  logic rd_pend = 1'b0;
  string qn[$];
  logic [7:0] qv[$];
  logic [31:0] seed = 32'hd066886d;
  logic [31:0] rv;
  logic [7:0] ua;
  logic [7:0] ecode [3] = '{8'h60, 8'he0, 8'h20};
  int ebit [3] = '{`CKS_BIT_SXT_ST, `CKS_BIT_ECK_ST, -1};
  logic [2:0] eact [3] = '{CKS_SRC_SLOW_XTAL, CKS_SRC_CLK_IN,
                           CKS_SRC_FAST_INT};
  logic [4:0] een [3] = '{5'b01011, 5'b10011, 5'b00011};
  logic [1:0] egp [3] = '{2'b00, 2'b01, 2'b11};

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  cks_clock_switch #(.SETTLE_CYC(3)) i_cks_clock_switch (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_fast_int_ready(ready[0]), .i_slow_int_ready(ready[1]),
    .i_fast_xtal_ready(ready[2]), .i_slow_xtal_ready(ready[3]),
    .i_clk_in_ready(ready[4]), .o_rdata(o_rdata),
    .o_active_source(o_active_source), .o_fast_int_en(en[0]),
    .o_slow_int_en(en[1]), .o_fast_xtal_en(en[2]),
    .o_slow_xtal_en(en[3]), .o_clk_in_en(en[4]),
    .o_crystal_in_pin_gpio(gp[1]), .o_crystal_out_pin_gpio(gp[0]));

  cks_osc_model i_cks_osc_model (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_en(en),
    .i_slow(slow), .o_ready(ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    if (qv.size() != 0) n_mismatch++;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken
  // at the falling edge of that cycle, away from the launching edge.
  always @(negedge i_ref_clk) begin
    if (rd_pend && qv.size() > 0)
      check(qn.pop_front(), o_rdata, qv.pop_front());
    rd_pend = i_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [7:0] e);
    qn.push_back(nm);
    qv.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(`CKS_OFF_TIMED, `CKS_KEY_FIRST);
    wr(`CKS_OFF_TIMED, `CKS_KEY_SECOND);
    wr(a, d);
  endtask

  task automatic outs(input logic [2:0] act, input logic [4:0] e,
                      input logic [1:0] g);
    @(negedge i_ref_clk);
    check("active", {5'h00, o_active_source}, {5'h00, act});
    check("enables", {3'h0, en}, {3'h0, e});
    check("port_pins", {6'h00, gp}, {6'h00, g});
    @(posedge i_ref_clk);
  endtask

  // Polls a stability bit; the queue is empty here, so the monitor ignores
  // these reads.
  task automatic poll(input int b);
    int i;
    for (i = 0; i < 300; i++) begin
      i_addr <= `CKS_OFF_SWITCH;
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      if (o_rdata[b] === 1'b1) break;
      @(posedge i_ref_clk);
    end
    if (i == 300) begin
      n_mismatch++;
      close_out();
    end
    @(posedge i_ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    poll(`CKS_BIT_FIO_ST);
    rd(`CKS_OFF_SWITCH, "switch", 8'h20);
    rd(`CKS_OFF_ENABLE, "enable", 8'h20);
    rv = $random(seed);
    ua = rv[7:0];
    if (ua inside {8'h96, 8'h97, 8'hc7}) ua = 8'h00;
    rd(ua, "unmapped", 8'h00);
    idle(2);
    outs(CKS_SRC_FAST_INT, 5'b00011, 2'b11);
    wr(`CKS_OFF_ENABLE, 8'h80);
    rv = $random(seed);
    wr(`CKS_OFF_TIMED, `CKS_KEY_FIRST);
    wr(`CKS_OFF_TIMED, `CKS_KEY_SECOND);
    wr(ua, rv[7:0]);
    wr(`CKS_OFF_ENABLE, 8'h80);
    pwr(`CKS_OFF_ENABLE, 8'h00);
    rd(`CKS_OFF_ENABLE, "enable", 8'h20);
    idle(2);
    outs(CKS_SRC_FAST_INT, 5'b00011, 2'b11);
    pwr(`CKS_OFF_SWITCH, 8'h02);
    rd(`CKS_OFF_SWITCH, "switch", 8'h22);
    rd(`CKS_OFF_ENABLE, "enable", 8'h21);
    slow <= 1'b1;
    pwr(`CKS_OFF_ENABLE, 8'ha0);
    idle(2);
    outs(CKS_SRC_FAST_INT, 5'b00111, 2'b11);
    rd(`CKS_OFF_ENABLE, "enable", 8'ha1);
    idle(2);
    poll(`CKS_BIT_FXT_ST);
    idle(3);
    outs(CKS_SRC_FAST_XTAL, 5'b00111, 2'b00);
    rd(`CKS_OFF_ENABLE, "enable", 8'ha0);
    rd(`CKS_OFF_SWITCH, "switch", 8'ha2);
    pwr(`CKS_OFF_ENABLE, 8'h60);
    rd(`CKS_OFF_ENABLE, "enable", 8'ha0);
    pwr(`CKS_OFF_SWITCH, 8'h00);
    idle(3);
    outs(CKS_SRC_FAST_INT, 5'b00111, 2'b11);
    slow <= 1'b0;
    // Slow crystal, clock-in and none enable codes, each then selected; with none the switch faults and fast internal stays.
    for (int k = 0; k < 3; k++) begin
      pwr(`CKS_OFF_ENABLE, ecode[k]);
      idle(2);
      if (ebit[k] >= 0) poll(ebit[k]);
      pwr(`CKS_OFF_SWITCH, 8'h02);
      idle(3);
      outs(eact[k], een[k], egp[k]);
      pwr(`CKS_OFF_SWITCH, 8'h00);
      idle(3);
    end
    pwr(`CKS_OFF_SWITCH, 8'h04);
    idle(3);
    outs(CKS_SRC_SLOW_INT, 5'b00011, 2'b11);
    pwr(`CKS_OFF_ENABLE, 8'h00);
    rd(`CKS_OFF_ENABLE, "enable", 8'h00);
    pwr(`CKS_OFF_SWITCH, 8'h06);
    rd(`CKS_OFF_ENABLE, "enable", 8'h01);
    rd(`CKS_OFF_SWITCH, "switch", 8'h06);
    idle(2);
    outs(CKS_SRC_SLOW_INT, 5'b00010, 2'b11);
    pwr(`CKS_OFF_ENABLE, 8'h20);
    idle(2);
    poll(`CKS_BIT_FIO_ST);
    idle(3);
    outs(CKS_SRC_FAST_INT, 5'b00011, 2'b11);
    rd(`CKS_OFF_ENABLE, "enable", 8'h20);
    pwr(`CKS_OFF_SWITCH, 8'h04);
    idle(3);
    outs(CKS_SRC_SLOW_INT, 5'b00011, 2'b11);
    // A second reset mid-run must bring back the power-up selection.
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    outs(CKS_SRC_FAST_INT, 5'b00011, 2'b11);
    rd(`CKS_OFF_ENABLE, "enable", 8'h20);
    idle(4);
    close_out();
  end
endmodule // cks_clock_switch_tb_top

// [verif/cks_osc_model.sv]
// Behavioural model of the five oscillators that feed the clock switch.
`timescale 1ns/10ps
module cks_osc_model #(
  parameter int unsigned START_FAST = 2,
  parameter int unsigned START_SLOW = 40
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [4:0] i_en,
  input wire logic i_slow,
  output logic [4:0] o_ready
);
  int unsigned cnt [5];
  // An oscillator stops at the first clock edge without its enable, so ready drops
  // then and the warm-up starts again from zero on the next enable.
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    for (int k = 0; k < 5; k++) begin
      if (!i_rst_b || !i_en[k]) begin
        cnt[k] <= 0;
        o_ready[k] <= 1'b0;
      end else if (cnt[k] < (i_slow ? START_SLOW : START_FAST)) begin
        cnt[k] <= cnt[k] + 1;
      end else begin
        o_ready[k] <= 1'b1;
      end
    end
  end
endmodule // cks_osc_model
